// File: shared/lcc_pkg.sv
// Constants, register map and types for the four-channel LED current control.
// Assumes one 200 MHz clock; all pins are synchronous to it.
// Summary of operation
// - Four independent LED channels, each with its own 8-bit current code and 8-bit PWM value.
// - A channel's sink current is its code times 0.1 mA, from zero at code 0 to 25.5 mA at all-ones.
// - Only a host write over the serial bus changes a current code; engines never touch it.
// - After reset every current code holds the 17.5 mA value until the host writes another.
// - Each channel takes its PWM either from its own written register or from a chosen engine.
// - Three program engines run ramp, set PWM, go to start, branch and end-with-trigger steps.
// - Once programs are loaded the engines run on their own with no further host traffic.
// - Engine timing steps on the external slow clock, so programs speed up or slow down with it.
package lcc_pkg;
  localparam int NUM_CH = 4;
  localparam int NUM_ENG = 3;
  localparam int PROG_WORDS = 16;

  // Clocking and PWM rates
  localparam int CLK_HZ = 200_000_000;
  localparam int PWM_LF_HZ = 256;
  localparam int PWM_HF_HZ = 558;
  localparam int PWM_STEPS = 256;
  localparam int PWM_DIV_LF = CLK_HZ / (PWM_LF_HZ * PWM_STEPS);
  localparam int PWM_DIV_HF = CLK_HZ / (PWM_HF_HZ * PWM_STEPS);
  localparam int SLOW_REF_HZ_X10 = 327;
  localparam int HOST_WAIT_MS = 1;

  // Current code scale and reset value
  localparam int CUR_STEP_UA = 100;
  localparam logic [7:0] CUR_RESET = 8'haf;

  // Register addresses, channel order blue, green, red, white
  localparam logic [7:0] ADR_ENGINE_RUN = 8'h00;
  localparam logic [3:0][7:0] ADR_PWM = {8'h0e, 8'h04, 8'h03, 8'h02};
  localparam logic [3:0][7:0] ADR_CUR = {8'h0f, 8'h07, 8'h06, 8'h05};
  localparam logic [7:0] ADR_CONFIG = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0c;
  localparam logic [7:0] ADR_PROG_BASE = 8'h10;
  localparam logic [7:0] ADR_PROG_END = 8'h70;
  localparam logic [7:0] ADR_ENG_SEL = 8'h70;

  // Field positions
  localparam int CFG_PWM_HF_BIT = 6;
  localparam int STAT_TRIG_LSB = 4;

  // Serial target address, upper five bits; value is arbitrary
  localparam logic [4:0] I2C_BASE_ADDR = 5'h0c;

  typedef enum logic [2:0] {
    OP_SET_PWM = 3'b000,
    OP_RAMP = 3'b001,
    OP_GO_START = 3'b010,
    OP_BRANCH = 3'b011,
    OP_END_TRIG = 3'b100
  } lcc_op_type;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_AACK = 3'b010,
    I2C_REG = 3'b011,
    I2C_WACK = 3'b100,
    I2C_WR = 3'b101,
    I2C_RD = 3'b110,
    I2C_RACK = 3'b111
  } lcc_i2c_st_type;
endpackage : lcc_pkg

// File: hdl/lcc_i2c_target.sv
// Serial bus target: address match, register pointer, write and read bytes.
// Assumes SCL and SDA are already synchronous to clk and slow beside it.
`timescale 1ns/1ps
module lcc_i2c_target (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe_n,
  input wire logic [1:0] addr_sel,
  // Register access
  output logic wr,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  import lcc_pkg::*;

  typedef struct packed {
    lcc_i2c_st_type st;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] ptr;
    logic rw;
    logic sda_low;
    logic scl_q;
    logic sda_q;
    logic wr;
    logic [7:0] waddr;
    logic [7:0] wdata;
  } lcc_i2c_type;

  lcc_i2c_type s, n;
  logic start_c, stop_c, rise_c, fall_c;

  assign start_c = scl && s.scl_q && s.sda_q && !sda_in;
  assign stop_c = scl && s.scl_q && !s.sda_q && sda_in;
  assign rise_c = scl && !s.scl_q;
  assign fall_c = !scl && s.scl_q;

  always_comb begin
    n = s;
    n.scl_q = scl;
    n.sda_q = sda_in;
    n.wr = 1'b0;
    if (start_c) begin
      n.st = I2C_ADDR;
      n.cnt = 4'd0;
      n.sda_low = 1'b0;
    end else if (stop_c) begin
      n.st = I2C_IDLE;
      n.sda_low = 1'b0;
    end else if (rise_c) begin
      if (s.st == I2C_ADDR || s.st == I2C_REG || s.st == I2C_WR) begin
        n.sh = {s.sh[6:0], sda_in};
        n.cnt = s.cnt + 4'd1;
      end else if (s.st == I2C_RACK && sda_in) begin
        n.st = I2C_IDLE;
      end
    end else if (fall_c) begin
      unique case (s.st)
        I2C_ADDR: if (s.cnt == 4'd8) begin
          if (s.sh[7:1] == {I2C_BASE_ADDR, addr_sel}) begin
            n.st = I2C_AACK;
            n.sda_low = 1'b1;
            n.rw = s.sh[0];
          end else begin
            n.st = I2C_IDLE;
          end
        end
        I2C_AACK, I2C_RACK: if (s.rw) begin
          n.st = I2C_RD;
          n.sh = rdata;
          n.sda_low = ~rdata[7];
          n.cnt = 4'd1;
        end else begin
          n.st = I2C_REG;
          n.sda_low = 1'b0;
          n.cnt = 4'd0;
        end
        I2C_REG: if (s.cnt == 4'd8) begin
          n.ptr = s.sh;
          n.st = I2C_WACK;
          n.sda_low = 1'b1;
        end
        I2C_WR: if (s.cnt == 4'd8) begin
          // Host write is the only path to any register except the run and trigger bits, which engines also change
          n.wr = 1'b1;
          n.waddr = s.ptr;
          n.wdata = s.sh;
          n.ptr = s.ptr + 8'd1;
          n.st = I2C_WACK;
          n.sda_low = 1'b1;
        end
        I2C_WACK: begin
          n.st = I2C_WR;
          n.sda_low = 1'b0;
          n.cnt = 4'd0;
        end
        I2C_RD: if (s.cnt == 4'd8) begin
          n.st = I2C_RACK;
          n.sda_low = 1'b0;
          n.ptr = s.ptr + 8'd1;
        end else begin
          n.sda_low = ~s.sh[6];
          n.sh = {s.sh[6:0], 1'b0};
          n.cnt = s.cnt + 4'd1;
        end
        I2C_IDLE: n.sda_low = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{st: I2C_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end

  assign sda_oe_n = ~s.sda_low;
  assign wr = s.wr;
  assign addr = s.wr ? s.waddr : s.ptr;
  assign wdata = s.wdata;
endmodule : lcc_i2c_target

// File: hdl/lcc_top.sv
// Four-channel LED current and PWM control with three program engines.
// Assumes one 200 MHz clock, synchronous pins and a host on the serial bus.
`timescale 1ns/1ps
module lcc_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Serial bus
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic [1:0] ADDR_SEL,
  // Engine timebase
  input wire logic EXT_SLOW_CLOCK_IN,
  // Channel sinks
  output logic [lcc_pkg::NUM_CH-1:0][7:0] LED_CURRENT_CODE,
  output logic [lcc_pkg::NUM_CH-1:0] LED_ON
);
  import lcc_pkg::*;

  typedef struct packed {
    logic [NUM_CH-1:0][7:0] cur;
    logic [NUM_CH-1:0][7:0] pwm;
    logic [7:0] eng_sel;
    logic pwm_hf;
    logic [NUM_ENG-1:0] run;
    logic [NUM_ENG-1:0] trig;
    logic [NUM_ENG-1:0][PROG_WORDS-1:0][15:0] prog;
    logic [NUM_ENG-1:0][3:0] pc;
    logic [NUM_ENG-1:0][7:0] eng_pwm;
    logic [NUM_ENG-1:0][3:0] lcnt;
    logic [NUM_ENG-1:0][3:0] wait_cnt;
    logic [NUM_ENG-1:0][3:0] ramp_time;
    logic [NUM_ENG-1:0][7:0] ramp_left;
    logic [NUM_ENG-1:0] ramp_dn;
    logic slow_q;
    logic [11:0] div;
    logic [7:0] slot;
    logic [NUM_CH-1:0] led_on;
  } lcc_state_type;

  lcc_state_type s, n;
  logic bus_wr;
  logic [7:0] bus_addr, bus_wdata, bus_rdata;
  logic [7:0] pidx;
  logic prog_hit, slow_tick;
  logic [11:0] div_lim;

  lcc_i2c_target u_i2c (
    .clk(CLK),
    .rstn(RSTN),
    .scl(SCL),
    .sda_in(SDA_IN),
    .sda_oe_n(SDA_OE_N),
    .addr_sel(ADDR_SEL),
    .wr(bus_wr),
    .addr(bus_addr),
    .wdata(bus_wdata),
    .rdata(bus_rdata)
  );

  assign pidx = bus_addr - ADR_PROG_BASE;
  assign prog_hit = bus_addr >= ADR_PROG_BASE && bus_addr < ADR_PROG_END;
  // Engines count slow clock edges, so their pace follows its rate
  assign slow_tick = EXT_SLOW_CLOCK_IN && !s.slow_q;
  assign div_lim = s.pwm_hf ? 12'(PWM_DIV_HF - 1) : 12'(PWM_DIV_LF - 1);

  // Register read decode; unmapped addresses read as zero
  always_comb begin
    bus_rdata = 8'h00;
    if (bus_addr == ADR_ENGINE_RUN) begin
      bus_rdata = {5'h00, s.run};
    end else if (bus_addr == ADR_CONFIG) begin
      bus_rdata = {1'b0, s.pwm_hf, 6'h00};
    end else if (bus_addr == ADR_STATUS) begin
      bus_rdata = {1'b0, s.trig, 1'b0, s.run};
    end else if (bus_addr == ADR_ENG_SEL) begin
      bus_rdata = s.eng_sel;
    end else if (prog_hit) begin
      bus_rdata = pidx[0] ? s.prog[pidx[6:5]][pidx[4:1]][7:0]
                          : s.prog[pidx[6:5]][pidx[4:1]][15:8];
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (bus_addr == ADR_PWM[c]) bus_rdata = s.pwm[c];
      if (bus_addr == ADR_CUR[c]) bus_rdata = s.cur[c];
    end
  end

  always_comb begin
    logic [15:0] ins;
    logic [1:0] sel;
    logic [7:0] val;
    ins = 16'h0000;
    sel = 2'b00;
    val = 8'h00;
    n = s;
    n.slow_q = EXT_SLOW_CLOCK_IN;

    // Host writes land first so that engine events in the same cycle win
    if (bus_wr) begin
      if (bus_addr == ADR_ENGINE_RUN) begin
        for (int e = 0; e < NUM_ENG; e++) begin
          if (bus_wdata[e] && !s.run[e]) begin
            n.pc[e] = 4'd0;
            n.wait_cnt[e] = 4'd0;
            n.ramp_left[e] = 8'd0;
            n.lcnt[e] = 4'd0;
          end
        end
        n.run = bus_wdata[NUM_ENG-1:0];
      end
      if (bus_addr == ADR_CONFIG) n.pwm_hf = bus_wdata[CFG_PWM_HF_BIT];
      if (bus_addr == ADR_STATUS) begin
        n.trig = s.trig & ~bus_wdata[STAT_TRIG_LSB +: NUM_ENG];
      end
      if (bus_addr == ADR_ENG_SEL) n.eng_sel = bus_wdata;
      if (prog_hit) begin
        if (pidx[0]) n.prog[pidx[6:5]][pidx[4:1]][7:0] = bus_wdata;
        else n.prog[pidx[6:5]][pidx[4:1]][15:8] = bus_wdata;
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (bus_addr == ADR_PWM[c]) n.pwm[c] = bus_wdata;
        if (bus_addr == ADR_CUR[c]) n.cur[c] = bus_wdata;
      end
    end

    // Engines run from loaded program with no host help
    for (int e = 0; e < NUM_ENG; e++) begin
      if (slow_tick && s.run[e]) begin
        ins = s.prog[e][s.pc[e]];
        if (s.wait_cnt[e] != 4'd0) begin
          n.wait_cnt[e] = s.wait_cnt[e] - 4'd1;
        end else if (s.ramp_left[e] != 8'd0) begin
          n.ramp_left[e] = s.ramp_left[e] - 8'd1;
          n.wait_cnt[e] = s.ramp_time[e];
          if (s.ramp_dn[e]) begin
            if (s.eng_pwm[e] != 8'h00) n.eng_pwm[e] = s.eng_pwm[e] - 8'd1;
          end else if (s.eng_pwm[e] != 8'hff) begin
            n.eng_pwm[e] = s.eng_pwm[e] + 8'd1;
          end
        end else begin
          n.pc[e] = s.pc[e] + 4'd1;
          // Opcodes 5 to 7 are not defined and step over
          case (ins[15:13])
            OP_SET_PWM: n.eng_pwm[e] = ins[7:0];
            OP_RAMP: begin
              n.ramp_dn[e] = ins[12];
              n.ramp_time[e] = ins[11:8];
              n.ramp_left[e] = ins[7:0];
              n.wait_cnt[e] = ins[11:8];
            end
            OP_GO_START: n.pc[e] = 4'd0;
            OP_BRANCH: if (s.lcnt[e] == ins[11:8]) begin
              n.lcnt[e] = 4'd0;
            end else begin
              n.lcnt[e] = s.lcnt[e] + 4'd1;
              n.pc[e] = ins[3:0];
            end
            OP_END_TRIG: begin
              n.run[e] = 1'b0;
              n.trig[e] = 1'b1;
              n.pc[e] = 4'd0;
            end
            default: ;
          endcase
        end
      end
    end

    // PWM slot timebase
    if (s.div == div_lim) begin
      n.div = 12'd0;
      n.slot = s.slot + 8'd1;
    end else begin
      n.div = s.div + 12'd1;
    end

    // Per-channel source select and compare
    for (int c = 0; c < NUM_CH; c++) begin
      sel = s.eng_sel[2*c +: 2];
      val = (sel == 2'b00) ? s.pwm[c] : s.eng_pwm[sel - 2'd1];
      n.led_on[c] = (val == 8'hff) || (val > s.slot);
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s <= '{cur: {NUM_CH{CUR_RESET}}, default: '0};
    end else begin
      s <= n;
    end
  end

  // Code drives the sink directly, one step per CUR_STEP_UA
  assign LED_CURRENT_CODE = s.cur;
  assign LED_ON = s.led_on;
  assign SDA_OUT = 1'b0;
endmodule : lcc_top

// File: verification/lcc_chk_chk.sv
// Port assertions for the LED current control top.
// Assumes it is bound to lcc_top on one clock domain.
`timescale 1ns/1ps
module lcc_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Serial bus
  input wire logic SCL,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  input wire logic [1:0] ADDR_SEL,
  // Engine and sinks
  input wire logic EXT_SLOW_CLOCK_IN,
  input wire logic [lcc_pkg::NUM_CH-1:0][7:0] LED_CURRENT_CODE,
  input wire logic [lcc_pkg::NUM_CH-1:0] LED_ON
);
  import lcc_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sda_out_low_a: assert property (SDA_OUT == 1'b0)
    else $error("SDA_OUT not low");
  // A code may only move inside an acked host write
  code_by_host_a: assert property (
    $changed(LED_CURRENT_CODE) |-> !SDA_OE_N && !SCL)
    else $error("Current code moved outside a host write");
  oe_scl_low_a: assert property ($changed(SDA_OE_N) |-> !SCL)
    else $error("SDA drive changed while SCL high");
  ack_hold_a: assert property ($fell(SDA_OE_N) |-> !SDA_OE_N[*3])
    else $error("SDA drive too short");
  rst_code_a: assert property (
    $rose(RSTN) |-> LED_CURRENT_CODE == {NUM_CH{CUR_RESET}})
    else $error("Current code not at reset value");
  rst_on_a: assert property ($rose(RSTN) |-> LED_ON == '0)
    else $error("Sink on after reset");
  rst_bus_a: assert property ($rose(RSTN) |-> SDA_OE_N)
    else $error("SDA driven after reset");
  code_settle_a: assert property (
    $changed(LED_CURRENT_CODE) |=> $stable(LED_CURRENT_CODE)[*2])
    else $error("Current code not steady after write");
  code_c: cover property ($changed(LED_CURRENT_CODE));
  ack_c: cover property ($fell(SDA_OE_N));
  on_c: cover property ($rose(LED_ON[1]));
  off_c: cover property ($fell(LED_ON[2]));
endmodule : lcc_chk
bind lcc_top lcc_chk lcc_chk_i (.CLK(CLK), .RSTN(RSTN), .SCL(SCL),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
  .ADDR_SEL(ADDR_SEL), .EXT_SLOW_CLOCK_IN(EXT_SLOW_CLOCK_IN),
  .LED_CURRENT_CODE(LED_CURRENT_CODE), .LED_ON(LED_ON));

// File: verification/lcc_host.sv
// Host controller model for the serial bus, open drain.
// Assumes a pulled-up wire; all changes land on falling clock edges.
`timescale 1ns/1ps
module lcc_host (
  // Clock and bus wire
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  // Idle bus before the first transfer
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold
  // SCL low and high each four clocks, above the three required
  task automatic put_bit(input logic b, output logic got);
    sda_drv = b;
    hold(2);
    scl = 1'b1;
    hold(4);
    got = sda;
    scl = 1'b0;
    hold(2);
  endtask : put_bit
  task automatic start();
    sda_drv = 1'b1;
    hold(2);
    scl = 1'b1;
    hold(4);
    sda_drv = 1'b0;
    hold(4);
    scl = 1'b0;
    hold(2);
  endtask : start
  task automatic stop();
    sda_drv = 1'b0;
    hold(2);
    scl = 1'b1;
    hold(4);
    sda_drv = 1'b1;
    hold(4);
  endtask : stop
  // Byte out MSB first, then the ninth bit: 1 releases, 0 acks a read
  task automatic xfer(input logic [7:0] d, input logic last,
      output logic [7:0] q, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], b);
      q[i] = b;
    end
    put_bit(last, b);
    ack = !b;
  endtask : xfer
endmodule : lcc_host

// File: verification/tb.sv
// Self-checking bench for the LED current control top.
// Assumes the host model on the serial pins and the bound checker.
`timescale 1ns/1ps
module tb;
  import lcc_pkg::*;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic EXT_SLOW_CLOCK_IN = 1'b0;
  logic [1:0] ADDR_SEL = 2'b10;
  logic SDA_OUT, SDA_OE_N, scl, sda_drv, sda;
  logic [NUM_CH-1:0][7:0] LED_CURRENT_CODE;
  logic [NUM_CH-1:0] LED_ON;
  int num_errors = 0;
  int num_checks = 0;
  // Pulled-up wire: low if either side pulls
  assign sda = sda_drv & SDA_OE_N;
  always #2.5 CLK = ~CLK;
  lcc_top lcc_top_i (.CLK(CLK), .RSTN(RSTN), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .ADDR_SEL(ADDR_SEL),
    .EXT_SLOW_CLOCK_IN(EXT_SLOW_CLOCK_IN),
    .LED_CURRENT_CODE(LED_CURRENT_CODE), .LED_ON(LED_ON));
  lcc_host lcc_host_i (.clk(CLK), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  task automatic stop_test();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [3:0][7:0] d, int n);
    logic [7:0] q;
    logic k, ok;
    lcc_host_i.start();
    lcc_host_i.xfer({I2C_BASE_ADDR, ADDR_SEL, 1'b0}, 1'b1, q, ok);
    lcc_host_i.xfer(a, 1'b1, q, k);
    ok = ok & k;
    for (int i = 0; i < n; i++) begin
      lcc_host_i.xfer(d[i], 1'b1, q, k);
      ok = ok & k;
    end
    lcc_host_i.stop();
    chk("write ack", 8'h01, {7'h0, ok});
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    lcc_host_i.start();
    lcc_host_i.xfer({I2C_BASE_ADDR, ADDR_SEL, 1'b0}, 1'b1, d, k);
    lcc_host_i.xfer(a, 1'b1, d, k);
    lcc_host_i.start();
    lcc_host_i.xfer({I2C_BASE_ADDR, ADDR_SEL, 1'b1}, 1'b1, d, k);
    lcc_host_i.xfer(8'hff, 1'b1, d, k);
    lcc_host_i.stop();
  endtask : rd
  task automatic tick();
    EXT_SLOW_CLOCK_IN = 1'b1;
    repeat (4) @(negedge CLK);
    EXT_SLOW_CLOCK_IN = 1'b0;
    repeat (4) @(negedge CLK);
  endtask : tick
  task automatic t_reset();
    for (int c = 0; c < NUM_CH; c++) begin
      chk("reset code", CUR_RESET, LED_CURRENT_CODE[c]);
    end
    chk("reset on", 8'h00, {4'h0, LED_ON});
  endtask : t_reset
  // Boundary codes, one channel at a time; others must not move
  task automatic t_codes();
    logic [3:0][7:0] v;
    logic [7:0] q, e;
    v = {8'hfe, 8'h01, 8'hff, 8'h00};
    for (int c = 0; c < NUM_CH; c++) begin
      wr(ADR_CUR[c], {24'h0, v[c]}, 1);
      for (int k = 0; k < NUM_CH; k++) begin
        e = (k <= c) ? v[k] : CUR_RESET;
        chk("code", e, LED_CURRENT_CODE[k]);
      end
    end
    rd(ADR_CUR[3], q);
    chk("code read", 8'hfe, q);
  endtask : t_codes
  task automatic t_burst();
    logic [7:0] q;
    logic k;
    lcc_host_i.start();
    lcc_host_i.xfer({I2C_BASE_ADDR, ~ADDR_SEL, 1'b0}, 1'b1, q, k);
    lcc_host_i.stop();
    chk("foreign ack", 8'h00, {7'h0, k});
    wr(ADR_CUR[0], {8'h0, 8'h33, 8'h22, 8'h11}, 3);
    for (int c = 0; c < 3; c++) begin
      chk("burst", 8'(8'h11 * (c + 1)), LED_CURRENT_CODE[c]);
    end
    chk("burst end", 8'hfe, LED_CURRENT_CODE[3]);
  endtask : t_burst
  task automatic t_direct();
    wr(ADR_ENG_SEL, 32'h0, 1);
    wr(ADR_PWM[2], 32'hff, 1);
    repeat (3) @(negedge CLK);
    chk("pwm full", 8'h01, {7'h0, LED_ON[2]});
    wr(ADR_PWM[2], 32'h0, 1);
    repeat (3) @(negedge CLK);
    chk("pwm zero", 8'h00, {7'h0, LED_ON[2]});
  endtask : t_direct
  // Engine 1 sets full PWM then ends; it may only step on slow ticks
  task automatic t_engine();
    logic [7:0] q;
    wr(ADR_PROG_BASE, {8'h00, 8'h80, 8'hff, 8'h00}, 4);
    wr(ADR_ENG_SEL, 32'h04, 1);
    wr(ADR_ENGINE_RUN, 32'h01, 1);
    repeat (20) @(negedge CLK);
    chk("no tick", 8'h00, {7'h0, LED_ON[1]});
    tick();
    chk("engine pwm", 8'h01, {7'h0, LED_ON[1]});
    tick();
    rd(ADR_STATUS, q);
    chk("ended", 8'h10, q);
    chk("code kept", 8'h22, LED_CURRENT_CODE[1]);
    wr(ADR_STATUS, 32'h10, 1);
    rd(ADR_STATUS, q);
    chk("trig clear", 8'h00, q);
  endtask : t_engine
  // Fresh reset keeps the slot counter at zero, so any nonzero PWM is on
  task automatic t_ramp();
    logic [7:0] q;
    RSTN = 1'b0;
    repeat (2) @(negedge CLK);
    RSTN = 1'b1;
    @(negedge CLK);
    t_reset();
    // Engine 2: set 02, ramp down 2 steps of 2 ticks, loop once, go to start
    wr(ADR_PROG_BASE + 8'h20, {8'h02, 8'h31, 8'h02, 8'h00}, 4);
    wr(ADR_PROG_BASE + 8'h24, {8'h00, 8'h40, 8'h00, 8'h61}, 4);
    wr(ADR_ENG_SEL, 32'h20, 1);
    wr(ADR_ENGINE_RUN, 32'h02, 1);
    repeat (5) tick();
    chk("ramp step", 8'h01, {7'h0, LED_ON[2]});
    tick();
    chk("ramp end", 8'h00, {7'h0, LED_ON[2]});
    repeat (3) tick();
    chk("branch back", 8'h01, {7'h0, LED_ON[2]});
    repeat (8) tick();
    chk("branch out", 8'h00, {7'h0, LED_ON[2]});
    tick();
    chk("go start", 8'h01, {7'h0, LED_ON[2]});
    rd(ADR_STATUS, q);
    chk("running", 8'h02, q);
    wr(ADR_ENGINE_RUN, 32'h0, 1);
    rd(ADR_PROG_BASE + 8'h22, q);
    chk("prog read", 8'h31, q);
    chk("code kept", CUR_RESET, LED_CURRENT_CODE[2]);
    wr(ADR_CONFIG, 32'h40, 1);
    rd(ADR_CONFIG, q);
    chk("pwm rate", 8'h40, q);
  endtask : t_ramp
  initial begin
    repeat (5) @(negedge CLK);
    RSTN = 1'b1;
    @(negedge CLK);
    t_reset();
    t_codes();
    t_burst();
    t_direct();
    t_engine();
    t_ramp();
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge CLK);
    num_errors++;
    stop_test();
  end
endmodule : tb
